// File: hw/interval_if.sv
// Interface between the port sequencer and its interval timer.
`timescale 1ns/1ps
interface interval_if #(parameter int W = 8);
   logic load;
   logic [W-1:0] count;
   logic expired;

   modport owner (output load, output count, input expired);
   modport timer (input load, input count, output expired);
endinterface : interval_if

// File: hw/interval_timer.sv
// Down-counting interval timer used to pace the memory port phases.
`timescale 1ns/1ps
module interval_timer
   import port_host_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   interval_if.timer tmr
);
   import port_host_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } timer_s;

   timer_s state_r;
   timer_s state_nxt;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      state_nxt = state_r;
      if (tmr.load)
      begin
         state_nxt.cnt = tmr.count;
      end
      else if (state_r.cnt != CNT_RESET)
      begin
         state_nxt.cnt = state_r.cnt - CNT_W'(1);
      end
   end

   assign tmr.expired = (state_r.cnt == CNT_RESET) && !tmr.load;

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= '{cnt: CNT_RESET};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

endmodule : interval_timer

// File: hw/port_host.sv
// Host controller that drives one port of an asynchronous dual-port memory.
`timescale 1ns/1ps
module port_host
   import port_host_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire port_host_pkg::op_e OP,
   input wire logic [port_host_pkg::ADDR_W-1:0] ADDR,
   input wire logic [port_host_pkg::DATA_W-1:0] WDATA,
   output logic READY,
   output logic DONE,
   output logic [port_host_pkg::DATA_W-1:0] RDATA,
   output logic FLAG_GRANTED,
   output logic CE_N,
   output logic FLAG_SELECT_N,
   output logic RW_N,
   output logic OE_N,
   output logic [port_host_pkg::ADDR_W-1:0] A,
   input wire logic [port_host_pkg::DATA_W-1:0] IO_IN,
   output logic [port_host_pkg::DATA_W-1:0] IO_OUT,
   output logic IO_OE
);
   import port_host_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE,
      S_SETUP,
      S_ZWAIT,
      S_DRIVE,
      S_RECOVER,
      S_FLAG_GAP,
      S_READ,
      S_TURN,
      S_END
   } phase_e;

   typedef struct packed {
      phase_e st;
      logic flag_op;
      logic readback;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic granted;
      logic ce_n;
      logic flag_select_n;
      logic rw_n;
      logic oe_n;
      logic io_oe;
      logic done;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
      logic load;
      logic [CNT_W-1:0] count;
   } host_s;

   localparam host_s HOST_RESET = '{
      st: S_IDLE, flag_op: 1'b0, readback: 1'b0, addr: '0, wdata: '0, rdata: '0,
      granted: 1'b0, ce_n: 1'b1, flag_select_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, io_oe: 1'b0,
      done: 1'b0, sync1: '0, sync2: '0, load: 1'b0, count: CNT_RESET};

   host_s state_r;
   host_s state_nxt;

   interval_if #(.W(CNT_W)) tmr ();

   // ==========================================================
   // Interval timer
   // ==========================================================
   interval_timer u_timer (
      .clk(CLK),
      .reset(RESET),
      .tmr(tmr.timer)
   );

   assign tmr.load = state_r.load;
   assign tmr.count = state_r.count;

   // Selects the pin pair for an access: chip select for the array, flag select for a flag.
   function automatic logic [1:0] select_pair(input logic flag);
      // Result is {flag select, chip select}; exactly one of the two is driven low.
      return flag ? 2'h1 : 2'h2;
   endfunction : select_pair

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.done = 1'b0;
      state_nxt.load = 1'b0;
      // Data pins pass two flip-flops before the sequencer looks at them.
      state_nxt.sync1 = IO_IN;
      state_nxt.sync2 = state_r.sync1;
      case (state_r.st)
         S_IDLE:
         begin
            if (REQ)
            begin
               // Address and data are latched only here, with every strobe high.
               state_nxt.addr = ADDR;
               state_nxt.wdata = WDATA;
               state_nxt.flag_op = (OP == OP_FLAG_WRITE_READ) || (OP == OP_FLAG_READ);
               state_nxt.readback = (OP == OP_FLAG_WRITE_READ);
               state_nxt.load = 1'b1;
               if (OP == OP_ARRAY_READ || OP == OP_FLAG_READ)
               begin
                  {state_nxt.flag_select_n, state_nxt.ce_n} = select_pair(OP == OP_FLAG_READ);
                  state_nxt.oe_n = 1'b0;
                  state_nxt.count = (OP == OP_FLAG_READ) ? TSAA_CYC : TAA_CYC;
                  state_nxt.st = S_READ;
               end
               else
               begin
                  // Select falls before the strobe, so the write starts from a settled port.
                  {state_nxt.flag_select_n, state_nxt.ce_n} = select_pair(OP == OP_FLAG_WRITE_READ);
                  state_nxt.oe_n = 1'b1;
                  state_nxt.count = SETUP_CYC;
                  state_nxt.st = S_SETUP;
               end
            end
         end
         S_SETUP:
         begin
            if (tmr.expired)
            begin
               state_nxt.rw_n = 1'b0;
               state_nxt.load = 1'b1;
               state_nxt.count = TWZ_CYC;
               state_nxt.st = S_ZWAIT;
            end
         end
         S_ZWAIT:
         begin
            // Device drivers are given their turn-off time before data goes out.
            if (tmr.expired)
            begin
               state_nxt.io_oe = 1'b1;
               state_nxt.load = 1'b1;
               state_nxt.count = TDW_CYC;
               state_nxt.st = S_DRIVE;
            end
         end
         S_DRIVE:
         begin
            if (tmr.expired)
            begin
               // Strobe rises first; select and data stay put through recovery.
               state_nxt.rw_n = 1'b1;
               state_nxt.load = 1'b1;
               state_nxt.count = TWR_CYC;
               state_nxt.st = S_RECOVER;
            end
         end
         S_RECOVER:
         begin
            if (tmr.expired)
            begin
               state_nxt.io_oe = 1'b0;
               state_nxt.flag_select_n = 1'b1;
               state_nxt.ce_n = 1'b1;
               state_nxt.load = 1'b1;
               if (state_r.readback)
               begin
                  state_nxt.count = TSWRD_CYC;
                  state_nxt.st = S_FLAG_GAP;
               end
               else
               begin
                  state_nxt.count = TWR_CYC;
                  state_nxt.st = S_TURN;
               end
            end
         end
         S_FLAG_GAP:
         begin
            if (tmr.expired)
            begin
               // Read-back keeps chip select high and uses the flag select only.
               state_nxt.flag_select_n = 1'b0;
               state_nxt.oe_n = 1'b0;
               state_nxt.load = 1'b1;
               state_nxt.count = TSAA_CYC;
               state_nxt.st = S_READ;
            end
         end
         S_READ:
         begin
            if (tmr.expired)
            begin
               state_nxt.rdata = state_r.sync2;
               // A flag reads the same on every pin; a low bit means this port owns it.
               state_nxt.granted = state_r.flag_op && !state_r.sync2[0];
               state_nxt.oe_n = 1'b1;
               state_nxt.ce_n = 1'b1;
               state_nxt.flag_select_n = 1'b1;
               state_nxt.load = 1'b1;
               state_nxt.count = THZ_CYC;
               state_nxt.st = S_TURN;
            end
         end
         S_TURN:
         begin
            if (tmr.expired)
            begin
               state_nxt.done = 1'b1;
               state_nxt.st = S_END;
            end
         end
         S_END:
         begin
            state_nxt.st = S_IDLE;
         end
         default:
         begin
            state_nxt = HOST_RESET;
         end
      endcase
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         state_r <= HOST_RESET;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign READY = (state_r.st == S_IDLE);
   assign DONE = state_r.done;
   assign RDATA = state_r.rdata;
   assign FLAG_GRANTED = state_r.granted;
   assign CE_N = state_r.ce_n;
   assign FLAG_SELECT_N = state_r.flag_select_n;
   assign RW_N = state_r.rw_n;
   assign OE_N = state_r.oe_n;
   assign A = state_r.addr;
   assign IO_OUT = state_r.wdata;
   assign IO_OE = state_r.io_oe;

endmodule : port_host

// File: hw/port_host_pkg.sv
// Constants and types shared by the dual-port memory host controller.
package port_host_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int ADDR_W = 14;
   localparam int DATA_W = 9;
   localparam int CNT_W = 8;

   // ==========================================================
   // Clock and pin timing in nanoseconds, and synchroniser stages
   // ==========================================================
   localparam int CLK_PERIOD_NS = 25;
   localparam int TSETUP_NS = 0;
   localparam int TWP_NS = 25;
   localparam int TWZ_NS = 20;
   localparam int TDW_NS = 15;
   localparam int TWR_NS = 2;
   localparam int TAA_NS = 35;
   localparam int TSAA_NS = 35;
   localparam int THZ_NS = 20;
   localparam int TSWRD_NS = 5;
   localparam int SYNC_STAGES = 2;

   // Converts a least time to whole clock cycles, never fewer than one.
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : min_cycles

   // ==========================================================
   // Cycle counts
   // ==========================================================
   localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(min_cycles(TSETUP_NS));
   localparam logic [CNT_W-1:0] TWZ_CYC = CNT_W'(min_cycles(TWZ_NS));
   localparam logic [CNT_W-1:0] TDW_CYC = CNT_W'(min_cycles((TWP_NS > TWZ_NS + TDW_NS) ? TWP_NS - TWZ_NS : TDW_NS));
   localparam logic [CNT_W-1:0] TWR_CYC = CNT_W'(min_cycles(TWR_NS));
   localparam logic [CNT_W-1:0] TAA_CYC = CNT_W'(min_cycles(TAA_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] TSAA_CYC = CNT_W'(min_cycles(TSAA_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] THZ_CYC = CNT_W'(min_cycles(THZ_NS));
   localparam logic [CNT_W-1:0] TSWRD_CYC = CNT_W'(min_cycles(TSWRD_NS));

   // ==========================================================
   // Reset values and commands
   // ==========================================================
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   typedef enum logic [1:0] {
      OP_ARRAY_WRITE = 2'h0,
      OP_ARRAY_READ = 2'h1,
      OP_FLAG_WRITE_READ = 2'h2,
      OP_FLAG_READ = 2'h3
   } op_e;

endpackage : port_host_pkg

// File: verif/dual_port_mem_model.sv
// Behavioural model of one port of the dual-port memory, with its flag latches.
`timescale 1ns/1ps
module dual_port_mem_model
   import port_host_pkg::*;
(
   input wire logic clk,
   input wire logic ce_n,
   input wire logic flag_select_n,
   input wire logic rw_n,
   input wire logic oe_n,
   input wire logic [ADDR_W-1:0] a,
   input wire logic [DATA_W-1:0] host_data,
   input wire logic host_oe,
   input wire logic other_holds,
   output logic [DATA_W-1:0] bus
);
   import port_host_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [7:0] own = 8'h00;
   logic [DATA_W-1:0] idle_r = 9'h0aa;
   logic arr_wr;
   logic flag_wr;
   logic dev_drv;
   assign arr_wr = !ce_n && !rw_n && flag_select_n;
   assign flag_wr = ce_n && !flag_select_n && !rw_n;
   // Drivers stay off whenever the strobe is low, so a late select never drives.
   assign dev_drv = !oe_n && rw_n && (ce_n != flag_select_n);
   always @(negedge arr_wr) mem[a] = bus;
   // Bit 0 low asks for the flag; it is lost while the far port holds it.
   always @(negedge flag_wr) own[a[2:0]] = !bus[0] && !other_holds;
   always @(posedge clk) idle_r <= ~idle_r;
   assign bus = host_oe ? host_data : dev_drv ? (ce_n ? {DATA_W{~own[a[2:0]]}} : mem[a]) : idle_r;
endmodule : dual_port_mem_model

// File: verif/port_host_chk.sv
// Concurrent checks on the memory-side pins and the READY/DONE handshake of the port host controller.
`timescale 1ns/1ps
module port_host_chk
   import port_host_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic READY,
   input wire logic DONE,
   input wire logic CE_N,
   input wire logic FLAG_SELECT_N,
   input wire logic RW_N,
   input wire logic OE_N,
   input wire logic [port_host_pkg::ADDR_W-1:0] A,
   input wire logic IO_OE
);
   import port_host_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   a_select_exclusive: assert property (!CE_N |-> FLAG_SELECT_N) else $error("both selects low");
   a_flag_keeps_ce: assert property (!FLAG_SELECT_N |-> CE_N && $past(CE_N)) else $error("ce low in flag");
   a_addr_quiet: assert property (!$stable(A) |-> RW_N && $past(RW_N)) else $error("address moved in write");
   a_strobe_selected: assert property (!RW_N |-> $stable(CE_N) && $stable(FLAG_SELECT_N) && (CE_N != FLAG_SELECT_N))
      else $error("select changed in write");
   a_no_drive_read: assert property (IO_OE |-> OE_N && $past(OE_N)) else $error("drive with oe low");
   a_oe_high_write: assert property (!RW_N |-> OE_N) else $error("oe low in write");
   a_data_at_end: assert property ($rose(RW_N) |-> $past(IO_OE) && IO_OE) else $error("no data at end");
   a_flag_gap: assert property ($fell(FLAG_SELECT_N) && !OE_N |-> $past(FLAG_SELECT_N) && $past(RW_N, 2))
      else $error("flag read too soon");
   a_done_single: assert property (DONE |=> !DONE && READY) else $error("done not a pulse");
   a_take_busy: assert property (REQ && READY |=> !READY [*8]) else $error("ready during op");
endmodule : port_host_chk

bind port_host port_host_chk i_chk (.CLK(CLK), .RESET(RESET), .REQ(REQ), .READY(READY), .DONE(DONE), .CE_N(CE_N),
   .FLAG_SELECT_N(FLAG_SELECT_N), .RW_N(RW_N), .OE_N(OE_N), .A(A), .IO_OE(IO_OE));

// File: verif/tb_dual_port_sram_write_semaphore.sv
// Self-checking bench for the port host controller against a memory model.
`timescale 1ns/1ps
module tb_dual_port_sram_write_semaphore;
   import port_host_pkg::*;
   logic clk = 0;
   logic reset = 1;
   logic req = 0;
   op_e op = OP_ARRAY_READ;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic ready, done, granted, ce_n, fsel_n, rw_n, oe_n, io_oe, other_holds = 0;
   logic [DATA_W-1:0] rdata, io_out, bus;
   logic [ADDR_W-1:0] a;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   port_host i_dut (.CLK(clk), .RESET(reset), .REQ(req), .OP(op), .ADDR(addr), .WDATA(wdata), .READY(ready),
      .DONE(done), .RDATA(rdata), .FLAG_GRANTED(granted), .CE_N(ce_n), .FLAG_SELECT_N(fsel_n), .RW_N(rw_n),
      .OE_N(oe_n), .A(a), .IO_IN(bus), .IO_OUT(io_out), .IO_OE(io_oe));
   dual_port_mem_model i_mem (.clk(clk), .ce_n(ce_n), .flag_select_n(fsel_n), .rw_n(rw_n), .oe_n(oe_n), .a(a),
      .host_data(io_out), .host_oe(io_oe), .other_holds(other_holds), .bus(bus));
   // ==========================================================
   // Clock, timeout and verdict
   // ==========================================================
   initial forever #12.5 clk = ~clk;
   task automatic report_and_stop();
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   // ==========================================================
   // Operations
   // ==========================================================
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      check({8'h00, done}, 9'h001);
   endtask : wait_done
   task automatic run_op(input op_e o, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
      while (ready !== 1'b1) @(negedge clk);
      req = 1;
      op = o;
      addr = ad;
      wdata = wd;
      @(negedge clk);
      req = 0;
      wait_done();
   endtask : run_op
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_array();
      run_op(OP_ARRAY_WRITE, 14'h3fff, 9'h1a5);
      run_op(OP_ARRAY_WRITE, 14'h0000, 9'h05a);
      run_op(OP_ARRAY_READ, 14'h3fff, 9'h000);
      check(rdata, 9'h1a5);
      run_op(OP_ARRAY_READ, 14'h0000, 9'h000);
      check(rdata, 9'h05a);
   endtask : t_array
   task automatic t_flag();
      run_op(OP_FLAG_WRITE_READ, 14'h0003, 9'h000);
      check(rdata, 9'h000);
      check({8'h00, granted}, 9'h001);
      run_op(OP_FLAG_READ, 14'h0003, 9'h000);
      check(rdata, 9'h000);
      run_op(OP_ARRAY_READ, 14'h0000, 9'h000);
      check({8'h00, granted}, 9'h000);
      run_op(OP_FLAG_WRITE_READ, 14'h0003, 9'h001);
      check(rdata, 9'h1ff);
   endtask : t_flag
   task automatic t_contend();
      other_holds = 1;
      run_op(OP_FLAG_WRITE_READ, 14'h0005, 9'h000);
      check({8'h00, granted}, 9'h000);
      check(rdata, 9'h1ff);
      other_holds = 0;
      run_op(OP_FLAG_WRITE_READ, 14'h0005, 9'h000);
      check({8'h00, granted}, 9'h001);
   endtask : t_contend
   task automatic t_refuse();
      while (ready !== 1'b1) @(negedge clk);
      req = 1;
      op = OP_ARRAY_WRITE;
      addr = 14'h0100;
      wdata = 9'h0c3;
      @(negedge clk);
      wdata = 9'h13c;
      repeat (3) @(negedge clk);
      req = 0;
      wait_done();
      run_op(OP_ARRAY_READ, 14'h0100, 9'h000);
      check(rdata, 9'h0c3);
   endtask : t_refuse
   initial
   begin
      repeat (16) @(negedge clk);
      reset = 0;
      t_array();
      t_flag();
      t_contend();
      t_refuse();
      report_and_stop();
   end
endmodule : tb_dual_port_sram_write_semaphore
